// ==== logic/dtc_timer.sv ====
// Purpose: two 8-bit timer/event counters with square-wave, pwm and cascade modes
// Assumes: software controls arrive as same-clock strobes and levels
// Notes:   clock select 2..7 counts every 2^(sel-1) system clocks
`timescale 1ns/100ps
`default_nettype none
module dtc_timer (
    input  wire logic                      i_clock,      // system clock, 25 MHz
    input  wire logic                      i_rst,        // synchronous reset, active high
    input  wire dtc_pkg::dtc_ctrl_type [1:0] i_ctrl,     // software controls per unit
    input  wire logic [1:0]                i_event_pin,  // external event pins
    input  wire logic [1:0]                i_port_latch, // port latch levels for port mode
    output dtc_pkg::dtc_status_type [1:0]  o_status,     // readable state per unit
    output logic [1:0]                     o_match_irq,  // match interrupt pulses
    output logic [1:0]                     o_wave_pin    // wave output pins
);
    // returns the prescaler tick for a clock select of 2..7
    function automatic logic presc_tick(input logic [dtc_pkg::PRESC_W-1:0] presc, input logic [2:0] sel);
        logic tick;
        tick = 1'b1;
        for (int i = 0; i < dtc_pkg::PRESC_W; i++) begin
            if (i < int'(sel) - 1) begin
                tick = tick & presc[i];
            end
        end
        return tick;
    endfunction

    logic [1:0] rise;                                  // synchronised rising edges
    logic [1:0] fall;                                  // synchronised falling edges

    // per-unit state
    dtc_pkg::dtc_mode_type [1:0]      mode_reg,  mode_next;   // mode control
    logic [1:0][7:0]                  cmp_reg,   cmp_next;    // compare values
    logic [1:0][7:0]                  cnt_reg,   cnt_next;    // counters
    logic [1:0][2:0]                  sel_reg,   sel_next;    // clock selects
    logic [1:0][dtc_pkg::PRESC_W-1:0] presc_reg, presc_next;  // prescalers
    logic [1:0]                       act_reg,   act_next;    // pwm active phase
    logic [1:0]                       wave_reg,  wave_next;   // wave flip-flops
    logic [1:0]                       irq_next;               // match pulses
    logic [1:0]                       pin_next;               // pin levels

    // working terms
    logic [1:0] pulse;                                 // count pulse per unit
    logic       cascade;                               // units joined
    logic       carry;                                 // lower wraps in cascade
    logic       match16;                               // sixteen-bit match

    // event pin edge detectors, one per unit
    for (genvar g = 0; g < dtc_pkg::UNITS; g++) begin : g_sync
        dtc_edge_sync u_sync (
            .i_clock (i_clock),
            .i_rst   (i_rst),
            .i_pin   (i_event_pin[g]),
            .o_rise  (rise[g]),
            .o_fall  (fall[g])
        );
    end

    // next-state logic for both units
    always_comb begin
        mode_next  = mode_reg;
        cmp_next   = cmp_reg;
        cnt_next   = cnt_reg;
        presc_next = presc_reg;
        act_next   = act_reg;
        wave_next  = wave_reg;
        irq_next   = 2'h0;
        pin_next   = 2'h0;
        pulse      = 2'h0;
        cascade    = mode_reg[dtc_pkg::UPPER].cascade_select;
        carry      = 1'b0;
        match16    = 1'b0;
        for (int u = 0; u < dtc_pkg::UNITS; u++) begin
            sel_next[u] = i_ctrl[u].clock_select;
            // pick the count pulse source
            if (sel_reg[u] == dtc_pkg::SEL_EVENT_RISE) begin
                pulse[u] = rise[u];
            end else if (sel_reg[u] == dtc_pkg::SEL_EVENT_FALL) begin
                pulse[u] = fall[u];
            end else begin
                pulse[u] = presc_tick(presc_reg[u], sel_reg[u]);
            end
            pulse[u] = pulse[u] & mode_reg[u].count_enable;
            // prescaler runs only while counting
            if (mode_reg[u].count_enable) begin
                presc_next[u] = presc_reg[u] + dtc_pkg::PRESC_ONE;
            end else begin
                presc_next[u] = dtc_pkg::PRESC_ZERO;
            end
        end
        // lower unit
        if (!mode_reg[dtc_pkg::LOWER].count_enable) begin
            cnt_next[dtc_pkg::LOWER] = dtc_pkg::COUNT_ZERO;
            act_next[dtc_pkg::LOWER] = 1'b0;
        end else if (cascade) begin
            match16 = {cnt_reg[dtc_pkg::UPPER], cnt_reg[dtc_pkg::LOWER]} ==
                      {cmp_reg[dtc_pkg::UPPER], cmp_reg[dtc_pkg::LOWER]};
            if (pulse[dtc_pkg::LOWER] && match16) begin
                cnt_next[dtc_pkg::LOWER] = dtc_pkg::COUNT_ZERO;
                irq_next[dtc_pkg::LOWER] = 1'b1;
                if (mode_reg[dtc_pkg::LOWER].active_level_or_toggle_enable) begin
                    wave_next[dtc_pkg::LOWER] = ~wave_reg[dtc_pkg::LOWER];
                end
            end else if (pulse[dtc_pkg::LOWER]) begin
                cnt_next[dtc_pkg::LOWER] = cnt_reg[dtc_pkg::LOWER] + dtc_pkg::COUNT_ONE;
                carry = cnt_reg[dtc_pkg::LOWER] == dtc_pkg::COUNT_MAX;
            end
        end else begin
            cnt_next[dtc_pkg::LOWER] = cnt_reg[dtc_pkg::LOWER];
        end
        // mode handling shared by both units, cascaded upper unit included
        for (int u = 0; u < dtc_pkg::UNITS; u++) begin
            if (u == dtc_pkg::UPPER && cascade) begin
                // upper unit follows the lower carry and ignores its own select
                if (!mode_reg[u].count_enable) begin
                    cnt_next[u] = dtc_pkg::COUNT_ZERO;
                end else if (match16 && pulse[dtc_pkg::LOWER]) begin
                    cnt_next[u] = dtc_pkg::COUNT_ZERO;
                end else if (carry) begin
                    cnt_next[u] = cnt_reg[u] + dtc_pkg::COUNT_ONE;
                    irq_next[u] = (cnt_reg[u] + dtc_pkg::COUNT_ONE) == cmp_reg[u];
                end
                act_next[u] = 1'b0;
            end else if (u == dtc_pkg::LOWER && cascade) begin
                cnt_next[u] = cnt_next[u];
            end else if (!mode_reg[u].count_enable) begin
                cnt_next[u] = dtc_pkg::COUNT_ZERO;
                act_next[u] = 1'b0;
            end else if (mode_reg[u].pwm_mode_select) begin
                // free-running pwm: active from overflow to compare match
                if (pulse[u]) begin
                    cnt_next[u] = cnt_reg[u] + dtc_pkg::COUNT_ONE;
                    if (cnt_reg[u] == dtc_pkg::COUNT_MAX) begin
                        act_next[u] = 1'b1;
                    end
                    if (cnt_next[u] == cmp_reg[u]) begin
                        act_next[u] = 1'b0;
                    end
                end
            end else if (pulse[u]) begin
                // clear and restart on match
                if (cnt_reg[u] == cmp_reg[u]) begin
                    cnt_next[u] = dtc_pkg::COUNT_ZERO;
                    irq_next[u] = 1'b1;
                    if (mode_reg[u].active_level_or_toggle_enable) begin
                        wave_next[u] = ~wave_reg[u];
                    end
                end else begin
                    cnt_next[u] = cnt_reg[u] + dtc_pkg::COUNT_ONE;
                end
            end
        end
        // software writes; a force command overrides a toggle in the same cycle
        for (int u = 0; u < dtc_pkg::UNITS; u++) begin
            if (i_ctrl[u].compare_we) begin
                cmp_next[u] = i_ctrl[u].compare_wdata;
            end
            if (i_ctrl[u].mode_we) begin
                mode_next[u] = i_ctrl[u].mode_wdata;
                mode_next[u].output_force_high = 1'b0;
                mode_next[u].output_force_low  = 1'b0;
                if (i_ctrl[u].mode_wdata.output_force_high && !i_ctrl[u].mode_wdata.output_force_low) begin
                    wave_next[u] = 1'b1;
                end else if (!i_ctrl[u].mode_wdata.output_force_high && i_ctrl[u].mode_wdata.output_force_low) begin
                    wave_next[u] = 1'b0;
                end
            end
            // pin: timer wave when enabled, port latch otherwise
            if (!mode_reg[u].wave_output_enable) begin
                pin_next[u] = i_port_latch[u];
            end else if (mode_reg[u].pwm_mode_select) begin
                pin_next[u] = act_next[u] ^ mode_reg[u].active_level_or_toggle_enable;
            end else begin
                pin_next[u] = wave_next[u];
            end
        end
    end

    // register stage
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            for (int u = 0; u < dtc_pkg::UNITS; u++) begin
                mode_reg[u]  <= dtc_pkg::MODE_RESET;
                cmp_reg[u]   <= dtc_pkg::COMPARE_RESET;
                cnt_reg[u]   <= dtc_pkg::COUNT_ZERO;
                sel_reg[u]   <= dtc_pkg::SEL_RESET;
                presc_reg[u] <= dtc_pkg::PRESC_ZERO;
            end
            act_reg     <= 2'h0;   // pwm starts inactive
            wave_reg    <= 2'h0;
            o_match_irq <= 2'h0;
            o_wave_pin  <= 2'h0;
        end else begin
            mode_reg    <= mode_next;
            cmp_reg     <= cmp_next;
            cnt_reg     <= cnt_next;
            sel_reg     <= sel_next;
            presc_reg   <= presc_next;
            act_reg     <= act_next;
            wave_reg    <= wave_next;
            o_match_irq <= irq_next;
            o_wave_pin  <= pin_next;
        end
    end

    // status mirrors registered state
    always_ff @(posedge i_clock) begin
        for (int u = 0; u < dtc_pkg::UNITS; u++) begin
            if (i_rst) begin
                o_status[u] <= '0;
            end else begin
                o_status[u].mode    <= mode_next[u];
                o_status[u].compare <= cmp_next[u];
                o_status[u].counter <= cnt_next[u];
            end
        end
    end

    // checks
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);

    for (genvar g = 0; g < dtc_pkg::UNITS; g++) begin : g_chk
        logic single;                                  // unit runs on its own
        assign single = !(cascade && (g == dtc_pkg::UPPER || g == dtc_pkg::LOWER)) || !cascade;

        sequence s_count_step;
            single && !mode_reg[g].pwm_mode_select && pulse[g] && cnt_reg[g] != cmp_reg[g];
        endsequence
        sequence s_match;
            single && !mode_reg[g].pwm_mode_select && pulse[g] && cnt_reg[g] == cmp_reg[g];
        endsequence

        a_edge_count_step: assert property (s_count_step |=> cnt_reg[g] == $past(cnt_reg[g]) + 8'h01)
            else $error("counter did not step on count pulse");
        // counter clear and interrupt pulse are registered on the same edge
        a_match_clear_irq: assert property (s_match |=> cnt_reg[g] == 8'h00 && o_match_irq[g])
            else $error("match did not clear counter and interrupt");
        a_match_wave_flip: assert property (
            (s_match and (mode_reg[g].active_level_or_toggle_enable && !i_ctrl[g].mode_we))
            |=> wave_reg[g] != $past(wave_reg[g]))
            else $error("wave flip-flop did not invert on match");
        a_stop_clears_cnt: assert property (
            !mode_reg[g].count_enable && !(cascade && g == dtc_pkg::UPPER)
            |=> cnt_reg[g] == 8'h00 && presc_reg[g] == 7'h00)
            else $error("stopped unit kept counting");
        a_force_high_set: assert property (
            i_ctrl[g].mode_we && i_ctrl[g].mode_wdata.output_force_high
            && !i_ctrl[g].mode_wdata.output_force_low |=> wave_reg[g])
            else $error("force high did not set wave flip-flop");
        a_force_reads_zero: assert property (
            i_ctrl[g].mode_we |-> ##2
            !o_status[g].mode.output_force_high && !o_status[g].mode.output_force_low)
            else $error("force bit read back as one");
        a_pwm_overflow_act: assert property (
            single && mode_reg[g].count_enable && mode_reg[g].pwm_mode_select
            && pulse[g] && cnt_reg[g] == 8'hFF && cmp_reg[g] != 8'h00 |=> act_reg[g])
            else $error("pwm not active after overflow");
        a_pwm_stop_idle: assert property (
            mode_reg[g].pwm_mode_select && !mode_reg[g].count_enable
            && mode_reg[g].wave_output_enable && !i_ctrl[g].mode_we
            |=> !act_reg[g] ##0 o_wave_pin[g] == mode_reg[g].active_level_or_toggle_enable)
            else $error("stopped pwm output not inactive");
        a_port_mode_pin: assert property (
            !mode_reg[g].wave_output_enable |=> o_wave_pin[g] == $past(i_port_latch[g]))
            else $error("port mode pin does not follow latch");
    end

    a_cascade_match16: assert property (
        cascade && pulse[dtc_pkg::LOWER] && match16
        |=> cnt_reg[0] == 8'h00 && cnt_reg[1] == 8'h00 && o_match_irq[0])
        else $error("sixteen-bit match did not clear both counters");
endmodule
`default_nettype wire

// ==== logic/dtc_pkg.sv ====
// Purpose: shared constants and carrier types for the dual 8-bit timer/event counter
// Assumes: one system clock, synchronous active-high reset
// Notes:   unit 0 is the lower unit, unit 1 the upper unit of a cascaded pair
package dtc_pkg;

    localparam int UNITS = 2;                      // number of 8-bit units
    localparam int LOWER = 0;                      // lower unit index
    localparam int UPPER = 1;                      // upper unit index
    localparam int PRESC_W = 7;                    // prescaler width

    localparam logic [7:0] COUNT_ZERO    = 8'h00;  // cleared counter value
    localparam logic [7:0] COUNT_ONE     = 8'h01;  // increment step
    localparam logic [7:0] COUNT_MAX     = 8'hFF;  // value before overflow
    localparam logic [7:0] COMPARE_RESET = 8'h00;  // compare value after reset
    localparam logic [7:0] MODE_RESET    = 8'h00;  // mode control after reset

    localparam logic [2:0] SEL_EVENT_RISE = 3'h0;  // count rising edges of the event pin
    localparam logic [2:0] SEL_EVENT_FALL = 3'h1;  // count falling edges of the event pin
    localparam logic [2:0] SEL_RESET      = 3'h0;  // clock select after reset

    localparam logic [PRESC_W-1:0] PRESC_ZERO = 7'h00;  // stopped prescaler
    localparam logic [PRESC_W-1:0] PRESC_ONE  = 7'h01;  // prescaler step

    // mode control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic count_enable;                   // bit 7: run / stop-and-clear
        logic pwm_mode_select;                // bit 6: free-running pwm
        logic reserved5;                      // bit 5: reads as written
        logic cascade_select;                 // bit 4: upper unit only
        logic output_force_high;              // bit 3: one-shot set of wave flip-flop
        logic output_force_low;               // bit 2: one-shot clear of wave flip-flop
        logic active_level_or_toggle_enable;  // bit 1: pwm active low / toggle enable
        logic wave_output_enable;             // bit 0: pin driven by timer
    } dtc_mode_type;

    // software controls of one unit
    typedef struct packed {
        dtc_mode_type mode_wdata;    // mode control write data
        logic         mode_we;       // mode control write strobe
        logic [7:0]   compare_wdata; // compare value write data
        logic         compare_we;    // compare value write strobe
        logic [2:0]   clock_select;  // count clock selection level
    } dtc_ctrl_type;

    // readable state of one unit
    typedef struct packed {
        dtc_mode_type mode;          // mode control readback
        logic [7:0]   compare;       // compare value readback
        logic [7:0]   counter;       // live counter value
    } dtc_status_type;

endpackage

// ==== logic/dtc_edge_sync.sv ====
// Purpose: synchronise the event pin and flag its edges
// Assumes: pin is asynchronous to i_clock
// Notes:   pulses appear three edges after the pin changes
`timescale 1ns/100ps
`default_nettype none
module dtc_edge_sync (
    input  wire logic i_clock,  // system clock
    input  wire logic i_rst,    // synchronous reset, active high
    input  wire logic i_pin,    // raw event pin
    output logic      o_rise,   // one-cycle rising-edge pulse
    output logic      o_fall    // one-cycle falling-edge pulse
);
    logic meta_reg,  meta_next;   // first synchroniser stage
    logic sync_reg,  sync_next;   // second synchroniser stage
    logic last_reg,  last_next;   // previous synchronised level
    logic rise_next, fall_next;   // edge pulses

    // next values; only the second stage reads the first
    always_comb begin
        meta_next = i_pin;
        sync_next = meta_reg;
        last_next = sync_reg;
        rise_next = sync_reg & ~last_reg;
        fall_next = ~sync_reg & last_reg;
    end

    // register stage
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
            o_rise   <= 1'b0;
            o_fall   <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            last_reg <= last_next;
            o_rise   <= rise_next;
            o_fall   <= fall_next;
        end
    end
endmodule
`default_nettype wire

// ==== dv/dtc_event_src.sv ====
// Purpose: event pin source for the timer's event inputs
// Assumes: edges spaced by at least two system clocks
// Notes:   level holds still while idle
`timescale 1ns/100ps
`default_nettype none
module dtc_event_src (
    input  wire logic       i_clock, // system clock
    input  wire logic       i_run,   // toggle pin while high
    input  wire logic [3:0] i_gap,   // clocks between edges minus one
    output logic            o_pin    // event pin level
);
    logic [3:0] cnt_reg = 4'h0;      // spacing counter
    initial o_pin = 1'b0;
    // toggle after each gap, keep the level when idle
    always @(posedge i_clock) begin
        if (i_run && cnt_reg >= i_gap) begin
            o_pin   <= ~o_pin;
            cnt_reg <= 4'h0;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ==== dv/dual_8bit_timer_event_counter_tb.sv ====
// Purpose: self-checking bench for the dual timer/event counter
// Assumes: inputs change at the falling clock edge
// Notes:   seeded random compare values and clock selects
`timescale 1ns/100ps
`default_nettype none
module dual_8bit_timer_event_counter_tb;
    logic clock = 1'b0;                     // 25 MHz system clock
    logic rst   = 1'b1;                     // synchronous reset
    dtc_pkg::dtc_ctrl_type   [1:0] ctrl;    // software controls
    dtc_pkg::dtc_status_type [1:0] status;  // readback
    logic [1:0] irq, wave, latch;           // interrupt, pins, port latches
    logic ev_run, ev_pin, last;             // event source control and level
    int n_errors = 0;
    int n_tests = 0;
    int c, hi, edges, cmp, sel;
    always #20 clock = ~clock;
    dtc_timer i_dtc_timer (.i_clock(clock), .i_rst(rst), .i_ctrl(ctrl), .i_event_pin({ev_pin, ev_pin}),
        .i_port_latch(latch), .o_status(status), .o_match_irq(irq), .o_wave_pin(wave));
    dtc_event_src i_dtc_event_src (.i_clock(clock), .i_run(ev_run), .i_gap(4'h2), .o_pin(ev_pin));
    task automatic tick(input int n); repeat (n) @(negedge clock); endtask
    // one compare for every kind of result
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    task automatic wr_mode(input int u, input logic [7:0] d);
        ctrl[u].mode_wdata = dtc_pkg::dtc_mode_type'(d);
        ctrl[u].mode_we = 1'b1;
        tick(1);
        ctrl[u].mode_we = 1'b0;
    endtask
    task automatic wr_cmp(input int u, input logic [7:0] d);
        ctrl[u].compare_wdata = d;
        ctrl[u].compare_we = 1'b1;
        tick(1);
        ctrl[u].compare_we = 1'b0;
    endtask
    // cycles until the next interrupt pulse, bounded
    task automatic wait_irq(input int u, output int cyc);
        cyc = 0;
        do begin tick(1); cyc++; end while (irq[u] !== 1'b1 && cyc < 4000);
        if (cyc >= 4000) chk(1'b0, 1'b1, "irq timeout");
    endtask
    function automatic logic [23:0] period(input int cv, input int s);
        return 24'((cv + 1) << (s - 1));
    endfunction
    task automatic tally_and_finish;
        if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin #3000000; n_errors++; tally_and_finish(); end
    initial begin
        ctrl = '0; ev_run = 1'b0; latch = 2'b00;
        void'($urandom(14));
        tick(10); rst = 1'b0; tick(1);
        chk(status[0], 24'h0, "reset state");
        // interval timer: corner compares then random
        for (int k = 0; k < 4; k++) begin
            cmp = (k == 0) ? 0 : (k == 1) ? 255 : $urandom_range(1, 20);
            sel = (k < 2) ? $urandom_range(2, 4) : $urandom_range(2, 7);
            ctrl[0].clock_select = 3'(sel);
            wr_cmp(0, 8'(cmp)); wr_mode(0, 8'h80);
            wait_irq(0, c); wait_irq(0, c);
            chk(c, period(cmp, sel), "interval");
            wr_mode(0, 8'h00); tick(1);
            chk(status[0].counter, 8'h00, "stop clears");
        end
        // event counting on each edge kind
        for (int s = 0; s < 2; s++) begin
            ctrl[0].clock_select = 3'(s); wr_cmp(0, 8'hFF); wr_mode(0, 8'h80);
            edges = 0; last = ev_pin;
            for (int i = 0; i < 45; i++) begin
                ev_run = (i < 40); tick(1);
                if ((s == 0) ? (ev_pin & ~last) : (~ev_pin & last)) edges++;
                last = ev_pin;
            end
            chk(status[0].counter, 24'(edges), "event count");
            wr_mode(0, 8'h00);
        end
        // port mode, force bits
        latch = 2'h1; tick(2); chk(wave, 2'h1, "port latch");
        latch = 2'h2; tick(2); chk(wave, 2'h2, "port latch");
        wr_mode(0, 8'h0B); chk(status[0].mode, 8'h03, "force readback");
        tick(1); chk(wave[0], 1'b1, "force high");
        wr_mode(0, 8'h07); chk(wave[0], 1'b0, "force low");
        // square wave, then toggling disabled
        ctrl[0].clock_select = 3'h2; wr_cmp(0, 8'h03); wr_mode(0, 8'h8B);
        wait_irq(0, c); last = wave[0]; wait_irq(0, c);
        chk(wave[0], !last, "square toggle");
        chk(c, period(3, 2), "square period");
        wr_mode(0, 8'h89); wait_irq(0, c); wait_irq(0, c);
        chk(wave[0], 1'b1, "no toggle");
        // pwm with both active levels
        for (int a = 0; a < 2; a++) begin
            wr_mode(0, {6'b010000, a[0], 1'b1}); wr_cmp(0, 8'h40);
            wr_mode(0, {6'b110000, a[0], 1'b1}); tick(1);
            chk(wave[0], a[0], "pwm start");
            tick(600); hi = 0;
            repeat (512) begin tick(1); if (wave[0] !== a[0]) hi++; end
            chk(hi, 24'h80, "pwm duty");
            wr_mode(0, {6'b010000, a[0], 1'b1}); tick(1);
            chk(wave[0], a[0], "pwm stop");
        end
        // cascade: upper first, then lower
        wr_mode(0, 8'h00); ctrl[1].clock_select = 3'($urandom_range(0, 7));
        wr_cmp(0, 8'h00); wr_cmp(1, 8'h01); wr_mode(1, 8'h90); wr_mode(0, 8'h80);
        wait_irq(0, c); wait_irq(0, c);
        chk(c, period(256, 2), "cascade period");
        chk(status[1].counter, 8'h00, "cascade clear");
        wait_irq(1, c); chk(c <= 514, 1'b1, "upper irq");
        tally_and_finish();
    end
endmodule
`default_nettype wire
